// file: design/vcpu_maint_ctl.sv
// maintenance status and virtual machine control state
`include "vcpu_maint_map.svh"
module vcpu_maint_ctl #(
    parameter int          NUM_ENTRIES = 16,
    parameter logic [2:0]  PREEMPTION_BIT_COUNT = 3'h4,
    parameter bit          SRE_ALWAYS_ON = 1'b0,
    parameter bit          HYP_IMPLEMENTED = 1'b1
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire vcpu_maint_pkg::event_en_t event_en,
    input  wire logic [4:0]              end_miss_counter,
    input  wire logic [NUM_ENTRIES-1:0]  end_of_irq_status,
    input  wire logic [2*NUM_ENTRIES-1:0] list_entry_state,
    input  wire logic [NUM_ENTRIES-1:0]  list_entry_from_packet,
    input  wire logic                    hyp_enabled,
    input  wire logic                    at_top_level,
    input  wire logic                    ctl_write,
    input  wire logic                    ctl_write_secure,
    input  wire logic [63:0]             ctl_wdata,
    input  wire logic                    view_bp1_write,
    input  wire logic [2:0]              view_bp1_wdata,
    input  wire logic                    pend_valid,
    input  wire logic [7:0]              pend_priority,
    input  wire logic                    pend_grp1,
    input  wire logic [9:0]              pend_id,
    input  wire logic                    end_write,
    input  wire logic                    deact_write,
    output logic [63:0]                  status_rdata,
    output logic [31:0]                  status_rdata32,
    output logic [63:0]                  ctl_rdata,
    output logic [31:0]                  ctl_rdata32,
    output logic [2:0]                   view_bp1_rdata,
    output logic                         maint_irq,
    output logic                         virt_irq,
    output logic                         virt_fiq,
    output logic [9:0]                   ack_id,
    output logic                         drop_priority,
    output logic                         deactivate
);
    if (NUM_ENTRIES < 1 || NUM_ENTRIES > 16)
    begin : g_bad_entries
        $error("NUM_ENTRIES out of range");
    end
    if (PREEMPTION_BIT_COUNT > 3'h6)
    begin : g_bad_preempt
        $error("PREEMPTION_BIT_COUNT out of range");
    end

    // ------------------------------------------------------------
    // binary point minimums
    // ------------------------------------------------------------
    localparam logic [2:0] BP0_MIN = `BP_MAX - PREEMPTION_BIT_COUNT;
    localparam logic [2:0] BP1_MIN_NS =
        (BP0_MIN == `BP_MAX) ? `BP_MAX : BP0_MIN + `BP_ONE;

    // ------------------------------------------------------------
    // maintenance status
    // ------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] next_status;
    logic       any_pending;
    logic [4:0] valid_count;
    vcpu_maint_pkg::vm_ctl_t ctl;
    vcpu_maint_pkg::vm_ctl_t next_ctl;

    always_comb
    begin
        any_pending = 1'b0;
        valid_count = 5'h0;
        for (int i = 0; i < NUM_ENTRIES; i++)
        begin
            if (!list_entry_from_packet[i])
            begin
                if (list_entry_state[2*i+`STATE_PENDING_BIT])
                    any_pending = 1'b1;
                if (list_entry_state[2*i +: 2] != `STATE_INACTIVE)
                    valid_count = valid_count + 5'h1;
            end
        end
        next_status = 8'h00;
        next_status[`STAT_GRP1_DIS] = event_en.grp1_disabled_event_en
            & ~ctl.virt_grp1_enable;
        next_status[`STAT_GRP1_EN] = event_en.grp1_enabled_event_en
            & ctl.virt_grp1_enable;
        next_status[`STAT_GRP0_DIS] = event_en.grp0_disabled_event_en
            & ~ctl.virt_grp0_enable;
        next_status[`STAT_GRP0_EN] = event_en.grp0_enabled_event_en
            & ctl.virt_grp0_enable;
        next_status[`STAT_NONE_PEND] = event_en.none_pending_event_en
            & ~any_pending;
        next_status[`STAT_ENTRY_MISS] = event_en.entry_missing_event_en
            & (end_miss_counter != 5'h0);
        next_status[`STAT_FEW_ENTRIES] = event_en.few_entries_event_en
            & (valid_count <= 5'h1);
        next_status[`STAT_END_OF_IRQ] = |end_of_irq_status;
        if (!hyp_enabled)
            next_status = 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            status <= 8'h00;
        else
            status <= next_status;
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_comb
    begin
        next_ctl = ctl;
        if (ctl_write && HYP_IMPLEMENTED)
        begin
            next_ctl.virt_priority_mask =
                ctl_wdata[`CTL_PMASK_HI:`CTL_PMASK_LO];
            next_ctl.grp0_binary_point =
                (ctl_wdata[`CTL_BP0_HI:`CTL_BP0_LO] < BP0_MIN) ?
                BP0_MIN : ctl_wdata[`CTL_BP0_HI:`CTL_BP0_LO];
            if (ctl_write_secure)
                next_ctl.grp1_binary_point =
                    (ctl_wdata[`CTL_BP1_HI:`CTL_BP1_LO] < BP0_MIN) ?
                    BP0_MIN : ctl_wdata[`CTL_BP1_HI:`CTL_BP1_LO];
            else
                next_ctl.grp1_binary_point =
                    (ctl_wdata[`CTL_BP1_HI:`CTL_BP1_LO] < BP1_MIN_NS) ?
                    BP1_MIN_NS : ctl_wdata[`CTL_BP1_HI:`CTL_BP1_LO];
            next_ctl.split_drop_deactivate_mode =
                ctl_wdata[`CTL_SPLIT_EOI];
            next_ctl.common_binary_point = ctl_wdata[`CTL_COMMON_BP];
            next_ctl.grp0_fast_route =
                SRE_ALWAYS_ON | ctl_wdata[`CTL_FAST_ROUTE];
            next_ctl.grp1_ack_control =
                ~SRE_ALWAYS_ON & ctl_wdata[`CTL_ACK_CTL];
            next_ctl.virt_grp1_enable = ctl_wdata[`CTL_GRP1_EN];
            next_ctl.virt_grp0_enable = ctl_wdata[`CTL_GRP0_EN];
        end
        else if (view_bp1_write && !ctl.common_binary_point)
        begin
            next_ctl.grp1_binary_point = (view_bp1_wdata < BP1_MIN_NS) ?
                BP1_MIN_NS : view_bp1_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl <= '0;
            ctl.virt_priority_mask <= `PRIO_RESET;
            ctl.grp0_binary_point <= BP0_MIN;
            ctl.grp1_binary_point <= BP1_MIN_NS;
            ctl.grp0_fast_route <= SRE_ALWAYS_ON;
        end
        else
            ctl <= next_ctl;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [63:0] ctl_word;
    logic [2:0]  bp1_view;
    logic        sig_ok;

    always_comb
    begin
        ctl_word = 64'h0000_0000_0000_0000;
        ctl_word[`CTL_PMASK_HI:`CTL_PMASK_LO] = ctl.virt_priority_mask;
        ctl_word[`CTL_BP0_HI:`CTL_BP0_LO] = ctl.grp0_binary_point;
        ctl_word[`CTL_BP1_HI:`CTL_BP1_LO] = ctl.grp1_binary_point;
        ctl_word[`CTL_SPLIT_EOI] = ctl.split_drop_deactivate_mode;
        ctl_word[`CTL_COMMON_BP] = ctl.common_binary_point;
        ctl_word[`CTL_FAST_ROUTE] = ctl.grp0_fast_route;
        ctl_word[`CTL_ACK_CTL] = ctl.grp1_ack_control;
        ctl_word[`CTL_GRP1_EN] = ctl.virt_grp1_enable;
        ctl_word[`CTL_GRP0_EN] = ctl.virt_grp0_enable;
        if (!HYP_IMPLEMENTED && at_top_level)
            ctl_word = 64'h0000_0000_0000_0000;
        if (ctl.common_binary_point)
            bp1_view = (ctl.grp0_binary_point == `BP_MAX) ? `BP_MAX :
                ctl.grp0_binary_point + `BP_ONE;
        else
            bp1_view = ctl.grp1_binary_point;
        sig_ok = hyp_enabled && pend_valid
            && (pend_priority < ctl.virt_priority_mask)
            && (pend_grp1 ? ctl.virt_grp1_enable : ctl.virt_grp0_enable);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_rdata   <= 64'h0000_0000_0000_0000;
            status_rdata32 <= 32'h0000_0000;
            ctl_rdata      <= 64'h0000_0000_0000_0000;
            ctl_rdata32    <= 32'h0000_0000;
            view_bp1_rdata <= 3'h0;
            maint_irq      <= 1'b0;
            virt_irq       <= 1'b0;
            virt_fiq       <= 1'b0;
            ack_id         <= 10'h000;
            drop_priority  <= 1'b0;
            deactivate     <= 1'b0;
        end
        else
        begin
            status_rdata   <= {56'h0, status};
            status_rdata32 <= {24'h0, status};
            ctl_rdata      <= ctl_word;
            ctl_rdata32    <= ctl_word[31:0];
            view_bp1_rdata <= bp1_view;
            maint_irq      <= |status;
            virt_irq <= sig_ok && (pend_grp1 || !ctl.grp0_fast_route);
            virt_fiq <= sig_ok && !pend_grp1 && ctl.grp0_fast_route;
            ack_id <= (pend_grp1 && !ctl.grp1_ack_control) ?
                `ID_SPURIOUS_GRP1 : pend_id;
            drop_priority  <= end_write && hyp_enabled;
            deactivate <= hyp_enabled && ((end_write &&
                !ctl.split_drop_deactivate_mode) || (deact_write &&
                ctl.split_drop_deactivate_mode));
        end
    end
endmodule // vcpu_maint_ctl

// file: design/vcpu_maint_map.svh
// register map and field positions for the maintenance and vm control block
`ifndef VCPU_MAINT_MAP_SVH
`define VCPU_MAINT_MAP_SVH
`define STAT_GRP1_DIS     7
`define STAT_GRP1_EN      6
`define STAT_GRP0_DIS     5
`define STAT_GRP0_EN      4
`define STAT_NONE_PEND    3
`define STAT_ENTRY_MISS   2
`define STAT_FEW_ENTRIES  1
`define STAT_END_OF_IRQ   0
`define CTL_PMASK_HI      31
`define CTL_PMASK_LO      24
`define CTL_BP0_HI        23
`define CTL_BP0_LO        21
`define CTL_BP1_HI        20
`define CTL_BP1_LO        18
`define CTL_SPLIT_EOI     9
`define CTL_COMMON_BP     4
`define CTL_FAST_ROUTE    3
`define CTL_ACK_CTL       2
`define CTL_GRP1_EN       1
`define CTL_GRP0_EN       0
`define BP_MAX            3'h7
`define BP_ONE            3'h1
`define PRIO_RESET        8'h00
`define ID_SPURIOUS_GRP1  10'h3_FE
`define STATE_INACTIVE    2'h0
`define STATE_PENDING_BIT 0
`endif

// file: design/vcpu_maint_pkg.sv
// types shared by the maintenance and vm control block
package vcpu_maint_pkg;
    typedef struct packed {
        logic grp1_disabled_event_en;
        logic grp1_enabled_event_en;
        logic grp0_disabled_event_en;
        logic grp0_enabled_event_en;
        logic none_pending_event_en;
        logic entry_missing_event_en;
        logic few_entries_event_en;
    } event_en_t;

    typedef struct packed {
        logic [7:0] virt_priority_mask;
        logic [2:0] grp0_binary_point;
        logic [2:0] grp1_binary_point;
        logic       split_drop_deactivate_mode;
        logic       common_binary_point;
        logic       grp0_fast_route;
        logic       grp1_ack_control;
        logic       virt_grp1_enable;
        logic       virt_grp0_enable;
    } vm_ctl_t;
endpackage

// file: sim/tb.sv
// self-checking bench for the maintenance and vm control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals, helpers and scenarios
    // ----------------------------------------
    logic        clk, rst, hyp_enabled, at_top_level, ctl_write;
    logic        ctl_write_secure, view_bp1_write, pend_valid, pend_grp1;
    logic        end_write, deact_write, maint_irq, virt_irq, virt_fiq;
    logic        drop_priority, deactivate;
    logic [4:0]  end_miss_counter;
    logic [15:0] end_of_irq_status, list_entry_from_packet;
    logic [31:0] list_entry_state, status_rdata32, ctl_rdata32;
    logic [63:0] ctl_wdata, status_rdata, ctl_rdata;
    logic [2:0]  view_bp1_wdata, view_bp1_rdata;
    logic [7:0]  pend_priority;
    logic [9:0]  pend_id, ack_id;
    int          n_errors, tests_run;
    vcpu_maint_pkg::event_en_t event_en;

    vcpu_maint_ctl DUT (.clk, .rst, .event_en, .end_miss_counter,
        .end_of_irq_status, .list_entry_state, .list_entry_from_packet,
        .hyp_enabled, .at_top_level, .ctl_write, .ctl_write_secure, .ctl_wdata,
        .view_bp1_write, .view_bp1_wdata, .pend_valid, .pend_priority,
        .pend_grp1, .pend_id, .end_write, .deact_write, .status_rdata,
        .status_rdata32, .ctl_rdata, .ctl_rdata32, .view_bp1_rdata, .maint_irq,
        .virt_irq, .virt_fiq, .ack_id, .drop_priority, .deactivate);

    always #4 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic sec, input logic [63:0] d);
        ctl_write = 1'b1;
        ctl_write_secure = sec;
        ctl_wdata = d;
        tick(1);
        ctl_write = 1'b0;
        tick(2);
    endtask
    task automatic vw(input logic [2:0] d);
        view_bp1_write = 1'b1;
        view_bp1_wdata = d;
        tick(1);
        view_bp1_write = 1'b0;
        tick(2);
    endtask
    task automatic st(input logic [6:0] ev, input logic [4:0] m,
                      input logic [15:0] e, input logic [15:0] p,
                      input logic [7:0] x);
        event_en = vcpu_maint_pkg::event_en_t'(ev);
        end_miss_counter = m;
        end_of_irq_status = e;
        list_entry_from_packet = p;
        tick(3);
        chk(status_rdata, {56'h0, x});
        chk(64'(status_rdata32), {56'h0, x});
        chk(64'(maint_irq), 64'(|x));
    endtask
    task automatic t_status;
        wr(1'b0, 64'h0);
        st(7'h7F, 5'h0, 16'h0, 16'h0, 8'hAA);
        wr(1'b0, 64'h3);
        list_entry_state = 32'h5;
        st(7'h7F, 5'h1, 16'h1, 16'h0, 8'h55);
        st(7'h7F, 5'h0, 16'h0, 16'h3, 8'h5A);
        st(7'h00, 5'h0, 16'h8, 16'h0, 8'h01);
        hyp_enabled = 1'b0;
        st(7'h7F, 5'h1, 16'h1, 16'h0, 8'h00);
        hyp_enabled = 1'b1;
        st(7'h7F, 5'h1, 16'h1, 16'h0, 8'h55);
        rst = 1'b1;
        tick(1);
        chk(status_rdata, 64'h0);
        rst = 1'b0;
        tick(2);
        chk(ctl_rdata, 64'h0070_0000);
    endtask
    task automatic t_ctl;
        wr(1'b0, 64'h0);
        chk(ctl_rdata, 64'h0070_0000);
        wr(1'b1, 64'h0);
        chk(ctl_rdata, 64'h006C_0000);
        wr(1'b0, '1);
        chk(ctl_rdata, 64'hFFFC_021F);
        chk(64'(ctl_rdata32), 64'hFFFC_021F);
    endtask
    task automatic t_view;
        wr(1'b0, 64'h00B4_0000);
        vw(3'h0);
        chk(64'(view_bp1_rdata), 64'h4);
        wr(1'b0, 64'h00A0_0010);
        vw(3'h7);
        chk(64'(view_bp1_rdata), 64'h6);
        chk(ctl_rdata, 64'h00B0_0010);
    endtask
    task automatic t_end(input logic [63:0] mode, input logic [63:0] exp);
        wr(1'b0, mode);
        end_write = 1'b1;
        tick(1);
        end_write = 1'b0;
        chk(64'({drop_priority, deactivate}), exp);
        tick(1);
        chk(64'({drop_priority, deactivate}), 64'h0);
        deact_write = mode[9];
        tick(1);
        deact_write = 1'b0;
        chk(64'({drop_priority, deactivate}), {63'h0, mode[9]});
    endtask
    task automatic t_sig;
        pend_valid = 1'b1;
        pend_priority = 8'h40;
        pend_id = 10'h025;
        wr(1'b0, 64'h8000_0001);
        tick(1);
        chk(64'({virt_irq, virt_fiq}), 64'h2);
        wr(1'b0, 64'h8000_0009);
        tick(1);
        chk(64'({virt_irq, virt_fiq}), 64'h1);
        pend_grp1 = 1'b1;
        wr(1'b0, 64'h8000_0002);
        tick(1);
        chk(64'({virt_irq, ack_id}), 64'h7FE);
        wr(1'b0, 64'h8000_0006);
        tick(1);
        chk(64'({virt_irq, ack_id}), 64'h425);
        pend_priority = 8'h80;
        tick(3);
        chk(64'(virt_irq), 64'h0);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #10000;
        n_errors++;
        test_done;
    end

    initial
    begin
        {clk, n_errors, tests_run, at_top_level, ctl_write} = '0;
        {ctl_write_secure, view_bp1_write, pend_valid, pend_grp1} = '0;
        {end_write, deact_write, end_miss_counter, pend_priority} = '0;
        {end_of_irq_status, list_entry_from_packet, list_entry_state} = '0;
        {ctl_wdata, view_bp1_wdata, pend_id} = '0;
        event_en = '0;
        rst = 1'b1;
        hyp_enabled = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(2);
        chk(ctl_rdata, 64'h0070_0000);
        t_status;
        t_ctl;
        t_view;
        t_end(64'h0, 64'h3);
        t_end(64'h200, 64'h2);
        t_sig;
        test_done;
    end
endmodule // tb

// file: sim/vcpu_maint_ctl_assertions.sv
// checker for the maintenance and vm control block
module vcpu_maint_ctl_checker #(
    parameter int         NUM_ENTRIES          = 16,
    parameter logic [2:0] PREEMPTION_BIT_COUNT = 3'h4
) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire vcpu_maint_pkg::event_en_t event_en,
    input wire logic [4:0]             end_miss_counter,
    input wire logic [NUM_ENTRIES-1:0] end_of_irq_status,
    input wire logic                   hyp_enabled,
    input wire logic                   end_write,
    input wire logic                   deact_write,
    input wire logic [63:0]            status_rdata,
    input wire logic [31:0]            status_rdata32,
    input wire logic [63:0]            ctl_rdata,
    input wire logic [31:0]            ctl_rdata32,
    input wire logic [2:0]             view_bp1_rdata,
    input wire logic                   maint_irq,
    input wire logic                   virt_fiq,
    input wire logic                   drop_priority,
    input wire logic                   deactivate
);
    // ----------------------------------------
    // settle counter and properties
    // ----------------------------------------
    logic [1:0] settle;
    logic [1:0] next_settle;
    always_comb next_settle = rst ? 2'h0 : settle + {1'b0, settle != 2'h3};
    always_ff @(posedge clk) settle <= next_settle;

    a_entry_miss_bit: assert property (@(posedge clk) disable iff (rst)
        settle == 2'h3 |-> status_rdata[2] == $past(hyp_enabled
        && event_en.entry_missing_event_en && end_miss_counter != 5'h0, 2))
        else $error("entry missing status bit wrong");
    a_end_irq_bit: assert property (@(posedge clk) disable iff (rst)
        settle == 2'h3 |-> status_rdata[0]
        == $past(hyp_enabled && (|end_of_irq_status), 2))
        else $error("end of irq status bit wrong");
    a_maint_or: assert property (@(posedge clk) disable iff (rst)
        maint_irq == (|status_rdata[7:0])) else $error("maint irq not or");
    a_upper_zero: assert property (@(posedge clk) disable iff (rst)
        status_rdata[63:8] == 56'h0 && ctl_rdata[63:32] == 32'h0
        && ctl_rdata[17:10] == 8'h0 && ctl_rdata[8:5] == 4'h0)
        else $error("reserved bits not zero");
    a_low_views: assert property (@(posedge clk) disable iff (rst)
        status_rdata32 == status_rdata[31:0] && ctl_rdata32 == ctl_rdata[31:0])
        else $error("32-bit view differs");
    a_reset_clear: assert property (@(posedge clk)
        $past(rst) |-> status_rdata == 64'h0 && !maint_irq)
        else $error("status not cleared by reset");
    a_bp0_floor: assert property (@(posedge clk) disable iff (rst)
        settle == 2'h3 |-> ctl_rdata[23:21] >= 3'h7 - PREEMPTION_BIT_COUNT)
        else $error("group 0 point below minimum");
    a_bp1_view: assert property (@(posedge clk) disable iff (rst)
        settle == 2'h3 && ctl_rdata[4] && $stable(ctl_rdata) |-> view_bp1_rdata
        == (ctl_rdata[23:21] == 3'h7 ? 3'h7 : ctl_rdata[23:21] + 3'h1))
        else $error("common point view wrong");
    a_end_drop: assert property (@(posedge clk) disable iff (rst)
        end_write && hyp_enabled |=> drop_priority) else $error("no drop");
    a_deact_cause: assert property (@(posedge clk) disable iff (rst)
        deactivate |-> $past(end_write || deact_write))
        else $error("deactivate without request");
    c_maint: cover property (@(posedge clk) disable iff (rst) maint_irq);
    c_drop_only: cover property (@(posedge clk) disable iff (rst)
        drop_priority && !deactivate);
    c_fiq: cover property (@(posedge clk) disable iff (rst) virt_fiq);
endmodule // vcpu_maint_ctl_checker

bind vcpu_maint_ctl vcpu_maint_ctl_checker #(.NUM_ENTRIES(NUM_ENTRIES),
    .PREEMPTION_BIT_COUNT(PREEMPTION_BIT_COUNT)) u_chk (.clk, .rst,
    .event_en, .end_miss_counter, .end_of_irq_status, .hyp_enabled,
    .end_write, .deact_write, .status_rdata, .status_rdata32, .ctl_rdata,
    .ctl_rdata32, .view_bp1_rdata, .maint_irq, .virt_fiq, .drop_priority,
    .deactivate);
